// File: hw/ixp_expander.sv
// Purpose: two-port 16-bit i/o expander core with i2c slave and change interrupt
// Assumes: scl and sda_in are sampled by mclk (40 MHz), far faster than the bus
// Notes: open-drain lines are drive-low only; the pad releases them when oe is low
//
// Notes on behaviour
// - any edge on an input pin flags interrupt
// - pins back to original or port read clears
// - read clears at ack rising edge before data
// - change during clearing ack pulse may vanish
// - later changes re-detected and re-assert interrupt
// - traffic for other addresses leaves interrupt alone
// - output pins never raise an interrupt
// - output-to-input switch may raise false interrupt
// - each port has its own interrupt source
// - interrupt line is open-drain, active low
// - three straps set low slave address bits
// - reset puts registers and bus fsm default
// - after reset accept requests, watch pins
// - input pin has both drivers off
// - output pin drives its output register bit
// - address byte is 0100, straps, direction
// - interrupt released within 4 us of scl
// - direction bit high reads, low writes
// - command byte after address selects register
`timescale 1ns/1ps
`default_nettype none

module ixp_expander
(
  input  wire logic                      mclk,
  input  wire logic                      rst,
  input  wire logic                      scl,
  input  wire logic                      sda_in,
  output logic                           sda_out,
  output logic                           sda_oe,
  input  wire logic                      strap_addr_bit0,
  input  wire logic                      strap_addr_bit1,
  input  wire logic                      strap_addr_bit2,
  input  wire logic [ixp_pkg::PORT_W-1:0] port_zero_bus_in,
  output logic      [ixp_pkg::PORT_W-1:0] port_zero_bus_out,
  output logic      [ixp_pkg::PORT_W-1:0] port_zero_bus_oe,
  input  wire logic [ixp_pkg::PORT_W-1:0] port_one_bus_in,
  output logic      [ixp_pkg::PORT_W-1:0] port_one_bus_out,
  output logic      [ixp_pkg::PORT_W-1:0] port_one_bus_oe,
  output logic                           irq_out,
  output logic                           irq_oe
);
  import ixp_pkg::*;

  ixp_state_t                      state_reg;
  logic                            scl_reg;
  logic                            sda_reg;
  logic [3:0]                      cnt_reg;
  logic [7:0]                      sh_reg;
  logic                            rw_reg;
  logic                            cmd_seen_reg;
  logic [2:0]                      cmd_reg;
  logic                            low_reg;
  logic [PORT_N-1:0][PORT_W-1:0]   out_reg;
  logic [PORT_N-1:0][PORT_W-1:0]   pol_reg;
  logic [PORT_N-1:0][PORT_W-1:0]   cfg_reg;
  logic [PORT_N-1:0][PORT_W-1:0]   oe_reg;
  logic [PORT_N-1:0][PORT_W-1:0]   pin_in;
  logic [PORT_N-1:0]               snap;
  logic [PORT_N-1:0]               pend;
  logic                            scl_rise;
  logic                            scl_fall;
  logic                            start_seen;
  logic                            stop_seen;
  logic                            byte_done;
  logic                            load_now;
  logic                            wr_now;
  logic [7:0]                      rd_byte;
  logic                            addr_hit;

  // bit n of each data byte is pin n of its port
  assign pin_in[0] = port_zero_bus_in;
  assign pin_in[1] = port_one_bus_in;

  // bus line history for edge and start/stop detection
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
    end
    else
    begin
      scl_reg <= scl;
      sda_reg <= sda_in;
    end
  end

  // bus events and the address compare
  assign scl_rise   = scl & ~scl_reg;
  assign scl_fall   = ~scl & scl_reg;
  assign start_seen = scl & scl_reg & sda_reg & ~sda_in;
  assign stop_seen  = scl & scl_reg & ~sda_reg & sda_in;
  assign byte_done  = scl_fall & (cnt_reg == BIT_LAST);
  assign addr_hit   = (sh_reg[7:1] == {ADDR_FIXED, strap_addr_bit2, strap_addr_bit1, strap_addr_bit0});

  // register fetch happens on the ack rising edge, just before the byte goes out
  assign load_now = scl_rise & ~start_seen & ~stop_seen &
                    (((state_reg == ST_AACK) & rw_reg) | ((state_reg == ST_RACK) & ~sda_in));
  assign wr_now   = byte_done & (state_reg == ST_RECV) & cmd_seen_reg;

  // read multiplexer: input ports are shown through the polarity mask
  always_comb
  begin
    rd_byte = 8'h00;
    case (cmd_reg[2:1])
      SEL_IN:  rd_byte = pin_in[cmd_reg[CMD_PORT_BIT]] ^ pol_reg[cmd_reg[CMD_PORT_BIT]];
      SEL_OUT: rd_byte = out_reg[cmd_reg[CMD_PORT_BIT]];
      SEL_POL: rd_byte = pol_reg[cmd_reg[CMD_PORT_BIT]];
      SEL_CFG: rd_byte = cfg_reg[cmd_reg[CMD_PORT_BIT]];
      default: rd_byte = 8'h00;
    endcase
  end

  // slave state machine; anything not matching our address drops to idle
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_reg    <= ST_IDLE;
      cnt_reg      <= 4'h0;
      sh_reg       <= 8'h00;
      rw_reg       <= 1'b0;
      cmd_seen_reg <= 1'b0;
      sda_oe       <= 1'b0;
    end
    else if (start_seen)
    begin
      state_reg <= ST_ADDR;
      cnt_reg   <= 4'h0;
      sda_oe    <= 1'b0;
    end
    else if (stop_seen)
    begin
      state_reg <= ST_IDLE;
      sda_oe    <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_ADDR, ST_RECV:
        begin
          if (scl_rise && cnt_reg != BIT_LAST)
          begin
            sh_reg  <= {sh_reg[6:0], sda_in};
            cnt_reg <= cnt_reg + 4'h1;
          end
          else if (byte_done)
          begin
            cnt_reg <= 4'h0;
            if (state_reg == ST_RECV)
            begin
              cmd_seen_reg <= 1'b1;
              state_reg    <= ST_WACK;
              sda_oe       <= 1'b1;
            end
            else if (addr_hit)
            begin
              rw_reg       <= sh_reg[0];
              cmd_seen_reg <= 1'b0;
              state_reg    <= ST_AACK;
              sda_oe       <= 1'b1;
            end
            else
              state_reg <= ST_IDLE;
          end
        end
        ST_AACK:
        begin
          if (load_now)
            sh_reg <= rd_byte;
          else if (scl_fall && rw_reg)
          begin
            state_reg <= ST_SEND;
            sda_oe    <= ~sh_reg[7];
            sh_reg    <= {sh_reg[6:0], 1'b0};
            cnt_reg   <= 4'h1;
          end
          else if (scl_fall)
          begin
            state_reg <= ST_RECV;
            sda_oe    <= 1'b0;
          end
        end
        ST_WACK:
        begin
          if (scl_fall)
          begin
            state_reg <= ST_RECV;
            sda_oe    <= 1'b0;
          end
        end
        ST_SEND:
        begin
          if (byte_done)
          begin
            state_reg <= ST_RACK;
            sda_oe    <= 1'b0;
            cnt_reg   <= 4'h0;
          end
          else if (scl_fall)
          begin
            sda_oe  <= ~sh_reg[7];
            sh_reg  <= {sh_reg[6:0], 1'b0};
            cnt_reg <= cnt_reg + 4'h1;
          end
        end
        ST_RACK:
        begin
          if (load_now)
            sh_reg <= rd_byte;
          else if (scl_rise)
            state_reg <= ST_IDLE;  // master nack ends the read
          else if (scl_fall)
          begin
            state_reg <= ST_SEND;
            sda_oe    <= ~sh_reg[7];
            sh_reg    <= {sh_reg[6:0], 1'b0};
            cnt_reg   <= 4'h1;
          end
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // command pointer: set by the command byte, then swaps within the register pair
  always_ff @(posedge mclk)
  begin
    if (rst)
      cmd_reg <= CMD_RST;
    else if (!start_seen && !stop_seen && byte_done && state_reg == ST_RECV && !cmd_seen_reg)
      cmd_reg <= sh_reg[2:0];
    else if (!start_seen && !stop_seen && byte_done && (state_reg == ST_SEND || wr_now))
      cmd_reg <= cmd_reg ^ 3'h1;
  end

  // writable registers and pin drivers; input-port writes are ignored
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      out_reg <= {PORT_N{OUT_RST}};
      pol_reg <= {PORT_N{POL_RST}};
      cfg_reg <= {PORT_N{CFG_RST}};
      oe_reg  <= {PORT_N{~CFG_RST}};
    end
    else if (wr_now && !start_seen && !stop_seen)
    begin
      case (cmd_reg[2:1])
        SEL_OUT: out_reg[cmd_reg[CMD_PORT_BIT]] <= sh_reg;
        SEL_POL: pol_reg[cmd_reg[CMD_PORT_BIT]] <= sh_reg;
        SEL_CFG:
        begin
          cfg_reg[cmd_reg[CMD_PORT_BIT]] <= sh_reg;
          oe_reg[cmd_reg[CMD_PORT_BIT]]  <= ~sh_reg;
        end
        default: ;
      endcase
    end
  end

  // one change detector per port, each cleared by its pins returning to the reference or by a read of its own port
  for (genvar p = 0; p < PORT_N; p++)
  begin : g_port
    assign snap[p] = load_now & (cmd_reg[2:1] == SEL_IN) & (cmd_reg[CMD_PORT_BIT] == 1'(p));
    ixp_port_irq #(.W(PORT_W)) u_irq
    (
      .mclk   (mclk),
      .rst    (rst),
      .pin_in (pin_in[p]),
      .dir_in (cfg_reg[p]),
      .snap   (snap[p]),
      .pend   (pend[p])
    );
  end

  // interrupt line pulled low while any port is pending; cleared two cycles after scl
  always_ff @(posedge mclk)
  begin
    if (rst)
      irq_oe <= 1'b0;
    else
      irq_oe <= |pend;
  end

  // constant low level for the open-drain pads
  always_ff @(posedge mclk)
  begin
    low_reg <= 1'b0;
  end

  assign sda_out           = low_reg;
  assign irq_out           = low_reg;
  assign port_zero_bus_out = out_reg[0];
  assign port_one_bus_out  = out_reg[1];
  assign port_zero_bus_oe  = oe_reg[0];
  assign port_one_bus_oe   = oe_reg[1];
endmodule

`default_nettype wire

// File: hw/ixp_port_irq.sv
// Purpose: shared constants and the per-port change detector of the i/o expander
// Assumes: pins are synchronous to mclk; dir_in bit high marks an input pin
// Notes: the reference byte is the pin state captured at reset or when the port was last read
`timescale 1ns/1ps
`default_nettype none

package ixp_pkg;
  localparam int         PORT_W        = 8;
  localparam int         PORT_N        = 2;
  localparam logic [3:0] ADDR_FIXED    = 4'h4;
  localparam logic [7:0] OUT_RST       = 8'hff;
  localparam logic [7:0] POL_RST       = 8'h00;
  localparam logic [7:0] CFG_RST       = 8'hff;
  localparam logic [2:0] CMD_RST       = 3'h0;
  localparam logic [1:0] SEL_IN        = 2'h0;
  localparam logic [1:0] SEL_OUT       = 2'h1;
  localparam logic [1:0] SEL_POL       = 2'h2;
  localparam logic [1:0] SEL_CFG       = 2'h3;
  localparam int         CMD_PORT_BIT  = 0;
  localparam logic [3:0] BIT_LAST      = 4'h8;
  localparam int         CLK_PERIOD_NS = 25;
  localparam int         IRQ_CLEAR_DELAY_NS  = 4000;
  localparam int         IRQ_CLEAR_DELAY_CYC = IRQ_CLEAR_DELAY_NS / CLK_PERIOD_NS;
  typedef enum {ST_IDLE, ST_ADDR, ST_AACK, ST_RECV, ST_WACK, ST_SEND, ST_RACK} ixp_state_t;
endpackage

module ixp_port_irq
#(
  parameter int W = 8
)
(
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic [W-1:0] pin_in,
  input  wire logic [W-1:0] dir_in,
  input  wire logic         snap,
  output logic              pend
);
  logic [W-1:0] ref_reg;

  // reference byte: follows the pins at reset and on each read of this port
  always_ff @(posedge mclk)
  begin
    if (rst)
      ref_reg <= pin_in;
    else if (snap)
      ref_reg <= pin_in;
  end

  // pending while any input pin differs from its reference; outputs are masked out
  always_ff @(posedge mclk)
  begin
    if (rst)
      pend <= 1'b0;
    else
      pend <= (|((pin_in ^ ref_reg) & dir_in)) & ~snap;
  end
endmodule

`default_nettype wire

// File: bench/ixp_expander_props.sv
// Purpose: concurrent checks on the expander top-level ports
// Assumes: one clock domain, mclk; rst synchronous active high
// Notes: helper flops remember last scl and pin levels to find the cause of an irq edge
`timescale 1ns/1ps
`default_nettype none
module ixp_expander_props
(
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       scl,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic [7:0] port_zero_bus_in,
  input wire logic [7:0] port_zero_bus_out,
  input wire logic [7:0] port_zero_bus_oe,
  input wire logic [7:0] port_one_bus_in,
  input wire logic [7:0] port_one_bus_out,
  input wire logic [7:0] port_one_bus_oe,
  input wire logic       irq_out,
  input wire logic       irq_oe
);
  logic       scl_q;
  logic [7:0] p0_q;
  logic [7:0] p1_q;
  // previous samples of scl and pins
  always_ff @(posedge mclk)
  begin
    scl_q <= scl;
    p0_q  <= port_zero_bus_in;
    p1_q  <= port_one_bus_in;
  end
  // change on an input pin, and any clearing cause
  wire logic chg_in = |((port_zero_bus_in ^ p0_q) & ~port_zero_bus_oe) | |((port_one_bus_in ^ p1_q) & ~port_one_bus_oe);
  wire logic chg    = chg_in | (scl & ~scl_q);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_quiet; !irq_oe [*2]; endsequence
  sequence s_hit; !irq_oe && chg_in; endsequence
  property p_rst; $fell(rst) |-> !irq_oe && !sda_oe && port_zero_bus_oe == 8'h00 && port_one_bus_oe == 8'h00
    && port_zero_bus_out == 8'hff && port_one_bus_out == 8'hff; endproperty
  property p_od; irq_out == 1'b0 && sda_out == 1'b0; endproperty
  property p_irq_set; s_quiet ##0 s_hit |-> ##[1:3] irq_oe; endproperty
  property p_irq_cause; $rose(irq_oe) |-> $past(chg_in, 2) || $past(chg_in, 3); endproperty
  property p_irq_fall; $fell(irq_oe) |-> $past(chg, 2) || $past(chg, 3) || $past(chg, 4); endproperty
  property p_p0_wr; $changed(port_zero_bus_out) || $changed(port_zero_bus_oe) |-> !scl && !$past(scl); endproperty
  property p_p1_wr; $changed(port_one_bus_out) || $changed(port_one_bus_oe) |-> !scl && !$past(scl); endproperty
  property p_sda; $changed(sda_oe) |-> !scl && !$past(scl); endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  a_od: assert property (p_od) else $error("open-drain data driven high");
  a_irq_set: assert property (p_irq_set) else $error("input change missed");
  a_irq_cause: assert property (p_irq_cause) else $error("irq without input change");
  a_irq_fall: assert property (p_irq_fall) else $error("irq cleared without cause");
  a_p0_wr: assert property (p_p0_wr) else $error("port0 register moved with scl high");
  a_p1_wr: assert property (p_p1_wr) else $error("port1 register moved with scl high");
  a_sda: assert property (p_sda) else $error("sda moved with scl high");
endmodule
bind ixp_expander ixp_expander_props u_props (.mclk(mclk), .rst(rst), .scl(scl), .sda_out(sda_out),
  .sda_oe(sda_oe), .port_zero_bus_in(port_zero_bus_in), .port_zero_bus_out(port_zero_bus_out),
  .port_zero_bus_oe(port_zero_bus_oe), .port_one_bus_in(port_one_bus_in), .port_one_bus_out(port_one_bus_out),
  .port_one_bus_oe(port_one_bus_oe), .irq_out(irq_out), .irq_oe(irq_oe));
`default_nettype wire

// File: bench/ixp_i2c_master.sv
// Purpose: bus master model driving scl and pulling sda low
// Assumes: sda is the resolved wire with its pull-up
// Notes: a quarter bit is Q mclk cycles; lines change just after an mclk rise
`timescale 1ns/1ps
`default_nettype none
module ixp_i2c_master
#(
  parameter int Q = 4
)
(
  input  wire logic mclk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  // bus idle: both lines released
  initial
  begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  task automatic wq(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // start or repeated start, entered with the bus idle or scl low
  task automatic start();
    sda_low <= 1'b0;
    wq(Q);
    scl <= 1'b1;
    wq(Q);
    sda_low <= 1'b1;
    wq(Q);
    scl <= 1'b0;
    wq(Q);
  endtask
  // stop leaves both lines high
  task automatic stop();
    sda_low <= 1'b1;
    wq(Q);
    scl <= 1'b1;
    wq(Q);
    sda_low <= 1'b0;
    wq(2 * Q);
  endtask
  // one bit: data set while scl low, sampled mid high
  task automatic xbit(input logic b, output logic r);
    sda_low <= ~b;
    wq(Q);
    scl <= 1'b1;
    wq(Q);
    r = sda;
    wq(Q);
    scl <= 1'b0;
    wq(Q);
  endtask
  // byte msb first then ack slot; release sda by sending ones
  task automatic xbyte(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
    xbit(ack_in, ack);
  endtask
endmodule
`default_nettype wire

// File: bench/tb.sv
// Purpose: directed test of the expander interrupt, port and addressing logic
// Assumes: straps at 3'b101, moved once to 3'b010 while reset is held
// Notes: pin level is the output bit where driven, else the bench's own level
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ixp_pkg::*;
  localparam logic [2:0] ST = 3'b101;
  logic [2:0] strap = ST;  // held steady whenever reset is released
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] p0_drv, p1_drv, d;
  logic [7:0] port_zero_bus_in, port_zero_bus_out, port_zero_bus_oe;
  logic [7:0] port_one_bus_in, port_one_bus_out, port_one_bus_oe;
  logic scl, sda_low, sda_out, sda_oe, irq_out, irq_oe;
  wire logic sda = ~(sda_low | sda_oe);
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  always #12.5 mclk = ~mclk;
  // resolve the pin levels
  assign port_zero_bus_in = (port_zero_bus_oe & port_zero_bus_out) | (~port_zero_bus_oe & p0_drv);
  assign port_one_bus_in = (port_one_bus_oe & port_one_bus_out) | (~port_one_bus_oe & p1_drv);
  ixp_i2c_master m (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(sda_low));
  ixp_expander DUT (.mclk(mclk), .rst(rst), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .strap_addr_bit0(strap[0]), .strap_addr_bit1(strap[1]), .strap_addr_bit2(strap[2]),
    .port_zero_bus_in(port_zero_bus_in), .port_zero_bus_out(port_zero_bus_out), .port_zero_bus_oe(port_zero_bus_oe),
    .port_one_bus_in(port_one_bus_in), .port_one_bus_out(port_one_bus_out), .port_one_bus_oe(port_one_bus_oe),
    .irq_out(irq_out), .irq_oe(irq_oe));
  task automatic conclude();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // write one byte to a register of the device strapped st; na is the expected ack level
  task automatic wr(input logic [2:0] st, input logic [7:0] cmd, input logic [7:0] v, input logic na);
    logic [7:0] q;
    logic [2:0] a;
    m.start();
    m.xbyte({ADDR_FIXED, st, 1'b0}, 1'b1, q, a[0]);
    m.xbyte(cmd, 1'b1, q, a[1]);
    m.xbyte(v, 1'b1, q, a[2]);
    m.stop();
    chk({5'h0, a}, {8{na}} & 8'h07);
  endtask
  // select a register then read one byte back
  task automatic rd(input logic [7:0] cmd, output logic [7:0] v);
    logic [7:0] q;
    logic [2:0] a;
    m.start();
    m.xbyte({ADDR_FIXED, ST, 1'b0}, 1'b1, q, a[0]);
    m.xbyte(cmd, 1'b1, q, a[1]);
    m.start();
    m.xbyte({ADDR_FIXED, ST, 1'b1}, 1'b1, q, a[2]);
    m.xbyte(8'hff, 1'b1, v, q[0]);
    m.stop();
    chk({5'h0, a}, 8'h00);
  endtask
  task automatic t_reset();
    chk(port_zero_bus_oe | port_one_bus_oe, 8'h00);
    chk(port_zero_bus_out & port_one_bus_out, 8'hff);
    chk({7'h0, irq_oe}, 8'h00);
  endtask
  task automatic t_change();
    p0_drv <= 8'h34;
    m.wq(4);
    chk({7'h0, irq_oe}, 8'h01);
    p0_drv <= 8'h3c;
    m.wq(4);
    chk({7'h0, irq_oe}, 8'h00);
  endtask
  task automatic t_split();
    p0_drv <= 8'h7c;
    m.wq(4);
    rd(8'h01, d);
    chk(d, 8'hc3);
    chk({7'h0, irq_oe}, 8'h01);
    rd(8'h00, d);
    chk(d, 8'h7c);
    chk({7'h0, irq_oe}, 8'h00);
    p0_drv <= 8'h3c;
    m.wq(4);
    chk({7'h0, irq_oe}, 8'h01);
    rd(8'h00, d);
    chk({7'h0, irq_oe}, 8'h00);
  endtask
  task automatic t_other();
    p1_drv <= 8'hc7;
    m.wq(4);
    wr(3'b100, 8'h00, 8'h00, 1'b1);
    chk({7'h0, irq_oe}, 8'h01);
    rd(8'h01, d);
    chk(d, 8'hc7);
    chk({7'h0, irq_oe}, 8'h00);
  endtask
  task automatic t_output();
    wr(ST, 8'h06, 8'h0f, 1'b0);
    chk(port_zero_bus_oe, 8'hf0);
    wr(ST, 8'h02, 8'ha5, 1'b0);
    chk(port_zero_bus_out, 8'ha5);
    chk(port_zero_bus_in, 8'hac);
    p0_drv <= 8'h0c;
    m.wq(4);
    chk({7'h0, irq_oe}, 8'h00);
    wr(ST, 8'h02, 8'h5a, 1'b0);
    chk(port_zero_bus_in, 8'h5c);
    chk({7'h0, irq_oe}, 8'h00);
  endtask
  // straps move only under reset, as a power cycle would; then the new address alone answers
  task automatic t_strap();
    rst <= 1'b1;
    strap <= 3'b010;
    m.wq(4);
    rst <= 1'b0;
    m.wq(4);
    t_reset();
    wr(3'b010, 8'h02, 8'h5a, 1'b0);
    chk(port_zero_bus_out, 8'h5a);
    wr(ST, 8'h02, 8'h00, 1'b1);
    chk(port_zero_bus_out, 8'h5a);
  endtask
  // bound the run length
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      conclude();
    end
  end
  // pins steady from time zero, reset for 20 cycles
  initial
  begin
    p0_drv = 8'h3c;
    p1_drv = 8'hc3;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    m.wq(4);
    t_reset();
    t_change();
    t_split();
    t_other();
    t_output();
    t_strap();
    conclude();
  end
endmodule
`default_nettype wire
